/* File: hdl/dbgch_counter.sv */
/*
  saturating cycle counter used for the elapsed-cycle read.
  assumes clear, run and zero come from logic on clk.
*/
`timescale 1ns/10ps
module dbgch_counter #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // handler side
  dbgch_cnt_if.cnt cif
);
  import dbgch_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  generate
    if (W < 2) begin : g_bad_width
      $error("counter width below two bits");
    end
  endgenerate

  logic [W-1:0] count_ff;      // running count
  logic [W-1:0] nxt_count;     // next count
  wire          at_max = &count_ff;  // all ones reached

  // saturate rather than wrap so a long run still reads as long
  assign nxt_count = (cif.zero || cif.clear) ? '0 :
                     (cif.run && !at_max)    ? count_ff + {{(W-1){1'b0}}, 1'b1} :
                     count_ff;

  // ----------------------------------------
  // counter register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign cif.value = count_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_saturate;
    @(posedge clk) disable iff (rst)
    (at_max && !cif.zero && !cif.clear) |=> (&count_ff) [*2] or (cif.zero || cif.clear);
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter left its maximum");

  property p_overwrite;
    @(posedge clk) disable iff (rst)
    cif.zero |=> (count_ff == '0);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("counter not overwritten");

  property p_step;
    @(posedge clk) disable iff (rst)
    (cif.run && !cif.zero && !cif.clear && !at_max) |=> (count_ff == $past(count_ff) + 1'b1);
  endproperty
  a_step: assert property (p_step) else $error("counter did not step by one");
endmodule : dbgch_counter

/* File: hdl/dbgch_top.sv */
/*
  debug command handler: takes command bytes from the debug host, answers
  revision, status, counter and control reads, writes the control register,
  and hands every other defined command, save stuff/execute under read-protect, to the rest of the debug unit.
  assumes the byte link, status and option inputs are already on clk.
*/
`timescale 1ns/10ps
module dbgch_top #(
  parameter logic [15:0] REVISION = dbgch_pkg::REV_DEFAULT,  // arbitrary value
  parameter int          CNT_W    = dbgch_pkg::CNT_WIDTH
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // byte link from the host
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_byte,
  // byte link to the host
  output logic            tx_valid_ff,
  output logic [7:0]      tx_byte_ff,
  input  wire logic       tx_ready,
  // device state
  input  wire logic       read_protect,
  input  wire logic [7:0] debug_status_reg,
  input  wire logic       cpu_running,
  input  wire logic       run_start,
  input  wire logic       cmd_clobber,
  // hand-off to the rest of the debug unit
  output logic            fwd_valid_ff,
  output logic [7:0]      fwd_cmd_ff,
  input  wire logic       fwd_done,
  // control register and refusal flag
  output logic [7:0]      debug_control_reg_ff,
  output logic            refused_ff
);
  import dbgch_pkg::*;

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  generate
    if (CNT_W != 16) begin : g_bad_cnt
      $error("answer path carries exactly two counter bytes");
    end
  endgenerate

  dbgch_state_e state_ff;      // handler state
  dbgch_state_e nxt_state;     // next handler state
  logic [15:0]  resp_ff;       // answer word held while bytes go out
  logic         fwd_se_ff;     // forwarded command is stuff or execute
  logic [7:0]   nxt_ctl;       // next control value
  logic [7:0]   nxt_tx_byte;   // next byte on offer

  dbgch_cnt_if #(.W(CNT_W)) cif ();

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire take      = rx_valid && (state_ff == ST_IDLE);   // command byte taken
  wire is_rev    = (rx_byte == CMD_READ_REV);
  wire is_stat   = (rx_byte == CMD_READ_STAT);
  wire is_cnt    = (rx_byte == CMD_READ_CNT);
  wire is_wctl   = (rx_byte == CMD_WRITE_CTL);
  wire is_rctl   = (rx_byte == CMD_READ_CTL);
  wire is_se     = (rx_byte == CMD_STUFF) || (rx_byte == CMD_EXEC);
  wire is_rsvd   = (rx_byte >= CMD_FIRST_RSVD);
  wire refuse    = is_se && read_protect;
  wire local_cmd = is_rev || is_stat || is_cnt || is_wctl || is_rctl;
  wire is_two    = is_rev || is_cnt;                                    // two-byte answers
  wire is_read   = is_two || is_stat || is_rctl;
  wire drop      = is_rsvd || refuse;
  wire do_fwd    = take && !local_cmd && !drop;
  wire wr_ctl    = rx_valid && (state_ff == ST_WDATA);
  wire tx_done   = tx_valid_ff && tx_ready;

  // read-protect keeps the mode bit pinned once set; reset or a write with read-protect low frees it
  assign nxt_ctl = {rx_byte[CTL_MODE_BIT] | (read_protect & debug_control_reg_ff[CTL_MODE_BIT]),
                    rx_byte[CTL_MODE_BIT-1:0]};

  // answer word selected at the moment the command is taken
  wire [15:0] read_word = is_rev  ? REVISION :
                          is_cnt  ? cif.value :
                          is_stat ? {8'h00, debug_status_reg} :
                          {8'h00, debug_control_reg_ff};

  // high byte leaves first, then the low byte
  assign nxt_tx_byte = (state_ff == ST_TX_HI) ? resp_ff[7:0] :
                       is_two ? read_word[15:8] : read_word[7:0];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take && !drop) begin
          if (is_wctl) begin
            nxt_state = ST_WDATA;        // data byte follows
          end else if (is_read) begin
            nxt_state = is_two ? ST_TX_HI : ST_TX_LO;
          end else begin
            nxt_state = ST_FWD;
          end
        end
      end
      ST_WDATA: begin
        if (rx_valid) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_TX_HI: begin
        if (tx_ready) begin
          nxt_state = ST_TX_LO;
        end
      end
      ST_TX_LO: begin
        if (tx_ready) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_FWD: begin
        if (fwd_done) begin
          nxt_state = ST_IDLE;           // rest of unit owns the link meanwhile
        end
      end
    endcase
  end

  // ----------------------------------------
  // state and answer registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      resp_ff  <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      if (take && is_read) begin
        resp_ff <= read_word;            // snapshot, later bytes stay coherent
      end
    end
  end

  // byte offered to the host, held until it accepts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_valid_ff <= 1'b0;
      tx_byte_ff  <= 8'h00;
    end else if ((take && is_read) || (tx_done && state_ff == ST_TX_HI)) begin
      tx_valid_ff <= 1'b1;
      tx_byte_ff  <= nxt_tx_byte;
    end else if (tx_done) begin
      tx_valid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_control_reg_ff <= CTL_RESET;
    end else if (wr_ctl) begin
      debug_control_reg_ff <= nxt_ctl;
    end
  end

  // ----------------------------------------
  // hand-off and refusal flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_valid_ff <= 1'b0;
      fwd_cmd_ff   <= 8'h00;
      fwd_se_ff    <= 1'b0;
      refused_ff   <= 1'b0;
    end else begin
      fwd_valid_ff <= do_fwd;            // one-cycle pulse
      refused_ff   <= take && drop;
      if (do_fwd) begin
        fwd_cmd_ff <= rx_byte;
        fwd_se_ff  <= is_se;
      end
    end
  end

  // ----------------------------------------
  // elapsed cycle counter
  // ----------------------------------------
  assign cif.clear = run_start;
  assign cif.run   = cpu_running;
  assign cif.zero  = cmd_clobber || ((state_ff == ST_FWD) && fwd_se_ff);

  dbgch_counter #(.W(CNT_W)) u_counter (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_first_byte(logic [7:0] b);
    tx_valid_ff && (tx_byte_ff == b) && (state_ff == ST_TX_HI);
  endsequence

  sequence s_last_byte(logic [7:0] b);
    tx_valid_ff && (tx_byte_ff == b) && (state_ff == ST_TX_LO);
  endsequence

  property p_refuse;
    @(posedge clk) disable iff (rst)
    (take && is_se && read_protect) |=> !fwd_valid_ff && !tx_valid_ff && (state_ff == ST_IDLE);
  endproperty
  a_refuse: assert property (p_refuse) else $error("protected command not refused");

  property p_rev;
    @(posedge clk) disable iff (rst)
    (take && is_rev) |=> s_first_byte(REVISION[15:8]);
  endproperty
  a_rev: assert property (p_rev) else $error("revision major byte missing");

  property p_order;
    @(posedge clk) disable iff (rst)
    (state_ff == ST_TX_HI && tx_ready) |=> s_last_byte($past(resp_ff[7:0]));
  endproperty
  a_order: assert property (p_order) else $error("low byte not after high byte");

  property p_stat;
    @(posedge clk) disable iff (rst)
    (take && is_stat) |=> s_last_byte($past(debug_status_reg));
  endproperty
  a_stat: assert property (p_stat) else $error("status byte wrong");

  property p_cnt;
    @(posedge clk) disable iff (rst)
    (take && is_cnt) |=> s_first_byte($past(cif.value[15:8]));
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter high byte wrong");

  property p_wctl;
    @(posedge clk) disable iff (rst)
    (take && is_wctl) ##1 (rx_valid && !read_protect) |=> (debug_control_reg_ff == $past(rx_byte));
  endproperty
  a_wctl: assert property (p_wctl) else $error("control write not loaded");

  property p_mode_pinned;
    @(posedge clk) disable iff (rst)
    (read_protect && debug_control_reg_ff[CTL_MODE_BIT]) |=> debug_control_reg_ff[CTL_MODE_BIT];
  endproperty
  a_mode_pinned: assert property (p_mode_pinned) else $error("mode bit cleared under protect");

  property p_rctl;
    @(posedge clk) disable iff (rst)
    (take && is_rctl) |=> s_last_byte($past(debug_control_reg_ff));
  endproperty
  a_rctl: assert property (p_rctl) else $error("control read wrong");

  property p_ignore;
    @(posedge clk) disable iff (rst)
    (take && drop) |=> $stable(debug_control_reg_ff) && !tx_valid_ff && !fwd_valid_ff && refused_ff;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored command had an effect");
endmodule : dbgch_top

/* File: shared/dbgch_cnt_if.sv */
/*
  carrier between the command handler and its cycle counter.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
interface dbgch_cnt_if #(parameter int W = 16);
  logic         clear;  // restart from zero at a breakpoint release
  logic         run;    // cpu is executing, count this cycle
  logic         zero;   // contents overwritten by a debug command
  logic [W-1:0] value;  // present count
  modport ctrl (output clear, output run, output zero, input value);
  modport cnt  (input clear, input run, input zero, output value);
endinterface : dbgch_cnt_if

/* File: shared/dbgch_pkg.sv */
/*
  constants shared by the debug command handler and its counter.
  assumes nothing of its surroundings beyond a sv-2012 compiler.
*/
package dbgch_pkg;
  // ----------------------------------------
  // command bytes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_REV   = 8'h00;  // debug_revision, two bytes
  localparam logic [7:0] CMD_READ_STAT  = 8'h02;  // debug_status_reg, one byte
  localparam logic [7:0] CMD_READ_CNT   = 8'h03;  // elapsed_cycle_counter, two bytes
  localparam logic [7:0] CMD_WRITE_CTL  = 8'h04;  // one data byte follows
  localparam logic [7:0] CMD_READ_CTL   = 8'h05;  // debug_control_reg, one byte
  localparam logic [7:0] CMD_STUFF      = 8'h11;  // stuff instruction
  localparam logic [7:0] CMD_EXEC       = 8'h12;  // execute instruction
  localparam logic [7:0] CMD_FIRST_RSVD = 8'h13;  // 13h..ffh carry no function
  // ----------------------------------------
  // control register layout, reset values, counter width and default revision
  // ----------------------------------------
  localparam int         CTL_MODE_BIT   = 7;      // debug_mode_bit position
  localparam logic [7:0] CTL_RESET      = 8'h00;  // normal operation after reset
  localparam int         CNT_WIDTH      = 16;     // elapsed_cycle_counter width
  localparam logic [15:0] REV_DEFAULT   = 16'h0100; // arbitrary value
  // ----------------------------------------
  // command handler states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,    // waiting for a command byte
    ST_WDATA,   // waiting for the control write byte
    ST_TX_HI,   // first of two answer bytes on offer
    ST_TX_LO,   // last answer byte on offer
    ST_FWD      // command handed to the rest of the debug unit
  } dbgch_state_e;
endpackage : dbgch_pkg

/* File: sim/dbgch_host.sv */
/*
  model of the external debug host: sends command and write bytes,
  takes answer bytes with a selectable stall.
  assumes the handler sits on the same clk and samples on its rising edge.
*/
`timescale 1ns/10ps
module dbgch_host (
  // clock
  input  wire logic       clk,
  // bytes to the handler
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  // answers from the handler
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte,
  output logic            tx_ready,
  // cycles to stall before taking a byte
  input  wire logic [3:0] stall
);
  // ----------------------------------------
  // idle link at time zero
  // ----------------------------------------
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
    tx_ready = 1'b0;
  end
  // one byte per call; callers send the command first, data next
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_byte  = b;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_byte  = ~b;  // released line: never the last value
  endtask : send
  // wait for an offered byte (bounded), stall, then take it
  task automatic take(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b0;
    b  = 8'h00;
    for (n = 0; n < 64 && !ok; n++) begin
      @(negedge clk);
      if (tx_valid === 1'b1) ok = 1'b1;
    end
    if (ok) begin
      repeat (stall) @(negedge clk);  // byte must stand meanwhile
      b = tx_byte;
      tx_ready = 1'b1;
      @(negedge clk);
      tx_ready = 1'b0;
    end
  endtask : take
endmodule : dbgch_host

/* File: sim/debug_command_handler_tb.sv */
/*
  self-checking bench for the debug command handler.
  assumes dbgch_pkg and the handler files are compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end
module debug_command_handler_tb;
  import dbgch_pkg::*;
  localparam logic [15:0] REV = 16'h3c5a;  // arbitrary value
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic       clk, rst, rx_valid, tx_valid_ff, tx_ready, read_protect;
  logic       cpu_running, run_start, cmd_clobber, fwd_valid_ff, fwd_done, refused_ff;
  logic [7:0] rx_byte, tx_byte_ff, debug_status_reg, fwd_cmd_ff, debug_control_reg_ff;
  logic [3:0] stall;                       // host stall length
  int         error_cnt, n_compared;       // tallies
  // ----------------------------------------
  // design and host model
  // ----------------------------------------
  dbgch_top #(.REVISION(REV), .CNT_W(16)) i_dut (.clk(clk), .rst(rst), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid_ff(tx_valid_ff), .tx_byte_ff(tx_byte_ff), .tx_ready(tx_ready),
    .read_protect(read_protect), .debug_status_reg(debug_status_reg), .cpu_running(cpu_running),
    .run_start(run_start), .cmd_clobber(cmd_clobber), .fwd_valid_ff(fwd_valid_ff),
    .fwd_cmd_ff(fwd_cmd_ff), .fwd_done(fwd_done), .debug_control_reg_ff(debug_control_reg_ff),
    .refused_ff(refused_ff));
  dbgch_host i_host (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid_ff),
    .tx_byte(tx_byte_ff), .tx_ready(tx_ready), .stall(stall));
  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // verdict and end of run, also reached on a hang
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // command, then nb answer bytes compared high byte first
  task automatic rd(input logic [7:0] cmd, input int nb, input logic [15:0] exp);
    logic [7:0] b;
    logic       ok;
    i_host.send(cmd);
    for (int i = nb - 1; i >= 0; i--) begin
      i_host.take(b, ok);
      if (!ok) begin
        error_cnt++;  // no answer within bound
        tally_and_finish();
      end
      `CHK(b, exp[8*i +: 8])
    end
  endtask : rd
  // control write: command byte then its data byte
  task automatic wr(input logic [7:0] d);
    i_host.send(CMD_WRITE_CTL);
    i_host.send(d);
  endtask : wr
  // six-cycle reset, released off the sampling edge
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reads();
    `CHK(tx_valid_ff, 1'b0)
    rd(CMD_READ_CTL, 1, 16'h0000);
    stall = 4'h2;                   // slow host: bytes must stand
    rd(CMD_READ_REV, 2, REV);
    debug_status_reg = 8'ha5;
    rd(CMD_READ_STAT, 1, 16'h00a5);
    debug_status_reg = 8'h5a;
    stall = 4'h0;
    rd(CMD_READ_STAT, 1, 16'h005a);
  endtask : t_reads
  task automatic t_ctl();
    wr(8'h5a);
    rd(CMD_READ_CTL, 1, 16'h005a);
    wr(8'ha3);
    wr(8'h00);                      // back-to-back writes clear mode bit
    rd(CMD_READ_CTL, 1, 16'h0000);
  endtask : t_ctl
  // protected: mode bit sticks, stuff/execute dropped
  task automatic t_protect();
    read_protect = 1'b1;
    wr(8'h80);
    wr(8'h01);
    `CHK(debug_control_reg_ff, 8'h81)
    rd(CMD_READ_CTL, 1, 16'h0081);
    for (int k = 0; k < 3; k++) begin
      i_host.send(k == 0 ? CMD_STUFF : k == 1 ? CMD_EXEC : 8'hff);
      `CHK({refused_ff, fwd_valid_ff, tx_valid_ff}, 3'b100)
    end
    rd(CMD_READ_CTL, 1, 16'h0081);
    read_protect = 1'b0;
    i_host.send(CMD_FIRST_RSVD);
    `CHK({refused_ff, fwd_valid_ff}, 2'b10)
    read_protect = 1'b1;
    do_reset();
    rd(CMD_READ_CTL, 1, 16'h0000);
    read_protect = 1'b0;
  endtask : t_protect
  // count, saturate, overwrite by clobber and by stuff hand-off
  task automatic t_counter();
    run_start = 1'b1;
    cpu_running = 1'b1;
    @(negedge clk);
    run_start = 1'b0;
    repeat (37) @(negedge clk);
    cpu_running = 1'b0;
    rd(CMD_READ_CNT, 2, 16'd37);
    cpu_running = 1'b1;
    repeat (65540) @(negedge clk);
    cpu_running = 1'b0;
    rd(CMD_READ_CNT, 2, 16'hffff);
    cmd_clobber = 1'b1;
    @(negedge clk);
    cmd_clobber = 1'b0;
    rd(CMD_READ_CNT, 2, 16'h0000);
    cpu_running = 1'b1;
    i_host.send(CMD_STUFF);
    `CHK({fwd_valid_ff, fwd_cmd_ff}, {1'b1, CMD_STUFF})
    repeat (5) @(negedge clk);
    cpu_running = 1'b0;
    fwd_done = 1'b1;
    @(negedge clk);
    fwd_done = 1'b0;
    rd(CMD_READ_CNT, 2, 16'h0000);
    // unprotected execute is handed off and also wipes the count
    cpu_running = 1'b1;
    i_host.send(CMD_EXEC);
    `CHK({fwd_valid_ff, fwd_cmd_ff}, {1'b1, CMD_EXEC})
    cpu_running = 1'b0;
    fwd_done = 1'b1;
    @(negedge clk);
    fwd_done = 1'b0;
    rd(CMD_READ_CNT, 2, 16'h0000);
  endtask : t_counter
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    n_compared = 0;
    stall = 4'h0;
    read_protect = 1'b0;
    debug_status_reg = 8'h00;
    cpu_running = 1'b0;
    run_start = 1'b0;
    cmd_clobber = 1'b0;
    fwd_done = 1'b0;
    do_reset();
    t_reads();
    t_ctl();
    t_protect();
    t_counter();
    tally_and_finish();
  end
endmodule : debug_command_handler_tb
